// *** design/cmr_regs.svh ***
// Purpose: constants of the cpu mode and register file block
// Assumes: apb byte addressing of aligned words, 50 MHz sys_clk_i
// Notes:   offsets are byte addresses of 32-bit aligned words
// Behaviour
// - normal mode limits linear addressing to 64 kbytes; here fetch_addr_o keeps pc bits 23 to 1, lsb zero, in both modes.
// - advanced mode addresses linearly over 16 Mbytes.
// - mode comes from external mode select pins driven by the system.
// - normal mode uses only the low 16 bits of effective addresses.
// - normal mode pointer carry or borrow propagates into the upper half.
// - normal vector table starts at zero, one 16-bit word per entry.
// - memory-indirect operand address comes from an 8-bit absolute field.
// - normal memory-indirect operand is a 16-bit word below 0x00ff.
// - advanced vectors are 32 bits; top 8 ignored, low 24 give target.
// - advanced memory-indirect operand is a longword, top byte read as zero.
// - upper halves act as standalone 16-bit or high half of 32 bits.
// - exception or call saves only pc and flags, never extended control.
// - eight identical 32-bit registers, accessible at 32, 16 or 8 bits.
// - each lower half splits into high and low byte registers.
// - access width is chosen per register independently; here one access setup register applies to all eight.
// - the eighth register is also the stack pointer.
// - pc is 24 bits; its lsb reads as zero on fetch.
// - trace bit 7 resets to 0, read/write, no effect.
// - bits 6 to 3 are reserved, read only, always one.
// - mask bits 2 to 0 reset to 1, read/write, no effect.
`ifndef CMR_REGS_SVH
`define CMR_REGS_SVH
// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define CMR_GREG_BASE     12'h000
`define CMR_PC_OFS        12'h020
`define CMR_EXTCTL_OFS    12'h024
`define CMR_MODE_OFS      12'h028
`define CMR_ACCESS_OFS    12'h02c
`define CMR_EA_OFS        12'h030
`define CMR_EA_OUT_OFS    12'h034
`define CMR_VEC_OFS       12'h038
`define CMR_VEC_OUT_OFS   12'h03c
`define CMR_PTR_OFS       12'h040
`define CMR_STACK_OFS     12'h044
// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define CMR_EXT_TRACE_BIT 7
`define CMR_EXT_RSVD_MASK 8'h78
`define CMR_EXT_RESET     8'h7f
`define CMR_NORM_EA_MASK  32'h0000ffff
`define CMR_ADV_EA_MASK   32'h00ffffff
`define CMR_PC_RESET      24'h000000
`define CMR_MI_LIMIT      32'h000000ff
`endif

// *** design/cmr_pkg.sv ***
// Purpose: types of the cpu mode and register file block
// Assumes: nothing beyond the register header
// Notes:   widths are the documented ones
package cmr_pkg;
   // register access width selector
   typedef enum logic [1:0] {
      CMR_W_LONG = 2'h0,
      CMR_W_WORD = 2'h1,
      CMR_W_BYTE = 2'h2
   } cmr_width_t;
   // operating mode, one-hot
   typedef enum logic [1:0] {
      CMR_MODE_NORMAL   = 2'h1,
      CMR_MODE_ADVANCED = 2'h2
   } cmr_mode_t;
   // apb slave phase, one-hot
   typedef enum logic [1:0] {
      CMR_BUS_IDLE = 2'h1,
      CMR_BUS_RESP = 2'h2
   } cmr_bus_t;
endpackage : cmr_pkg

// *** design/cmr_core.sv ***
// Purpose: general registers, pc, extended control and mode address logic
// Assumes: apb slave, no wait states, mode pins asynchronous to sys_clk_i
// Notes:   all outputs registered; registers reached as 32-bit words
//          the mode is caught once per reset, after the pin synchroniser fills
//          narrow register views zero extend on read
`timescale 1ns/100ps
`include "cmr_regs.svh"
module cmr_core (
   input  wire logic                sys_clk_i,
   input  wire logic                rst_i,
   input  wire logic                mode_sel_i,
   input  wire logic                psel_i,
   input  wire logic                penable_i,
   input  wire logic                pwrite_i,
   input  wire logic [11:0]         paddr_i,
   input  wire logic [31:0]         pwdata_i,
   output logic      [31:0]         prdata_o,
   output logic                     pready_o,
   output logic                     pslverr_o,
   output cmr_pkg::cmr_mode_t       mode_o,
   output logic      [23:0]         fetch_addr_o,
   output logic      [31:0]         stack_ptr_o
);
   import cmr_pkg::*;

   // ----------------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic [7:0][31:0] gregs;
      logic [23:0]      pc;
      logic [7:0]       extended_control;
      cmr_mode_t        mode;
      logic             mode_held;
      logic [1:0]       mode_sync;
      logic [1:0]       mode_fill;
      logic [7:0]       acc_ctl;
      logic [31:0]      ea_in;
      logic [31:0]      ea_out;
      logic [31:0]      vec_out;
      logic [31:0]      vec_raw;
      logic [31:0]      mi_addr;
      cmr_bus_t         bus;
      logic [31:0]      rdata;
      logic             ready;
      logic             slverr;
   } cmr_state_t;

   cmr_state_t st;
   cmr_state_t next_st;

   // merge narrow data into a register at the chosen width and lane
   function automatic logic [31:0] cmr_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input cmr_width_t  w,
                                              input logic        upper,
                                              input logic        hibyte);
      logic [31:0] r;
      r = old_v;
      unique case (w)
         CMR_W_LONG: r = new_v;
         CMR_W_WORD: begin
            if (upper) r[31:16] = new_v[15:0];
            else       r[15:0]  = new_v[15:0];
         end
         CMR_W_BYTE: begin
            if (hibyte) r[15:8] = new_v[7:0];
            else        r[7:0]  = new_v[7:0];
         end
         default:    r = old_v;
      endcase
      return r;
   endfunction : cmr_merge

   // extract a register view at the chosen width, zero extended
   function automatic logic [31:0] cmr_view(input logic [31:0] v,
                                             input cmr_width_t  w,
                                             input logic        upper,
                                             input logic        hibyte);
      logic [31:0] r;
      r = 32'h00000000;
      unique case (w)
         CMR_W_LONG: r = v;
         CMR_W_WORD: r = {16'h0000, upper ? v[31:16] : v[15:0]};
         CMR_W_BYTE: r = {24'h000000, hibyte ? v[15:8] : v[7:0]};
         default:    r = 32'h00000000;
      endcase
      return r;
   endfunction : cmr_view

   // mask an effective address to the mode's space
   function automatic logic [31:0] cmr_ea_mask(input logic [31:0] ea, input cmr_mode_t m);
      return (m == CMR_MODE_NORMAL) ? (ea & `CMR_NORM_EA_MASK)
                                    : (ea & `CMR_ADV_EA_MASK);
   endfunction : cmr_ea_mask

   // decoded fields of the current request
   logic [2:0]  idx;
   logic        is_greg;
   cmr_width_t  acc_w;
   logic        acc_up;
   logic        acc_hb;
   logic [2:0]  ptr_reg;
   logic        ptr_dec;
   logic [31:0] ptr_full;
   logic [31:0] ptr_step;

   // access setup fields: width [1:0], upper half [2], high byte [3]
   assign acc_w    = cmr_width_t'(st.acc_ctl[1:0]);
   assign acc_up   = st.acc_ctl[2];
   assign acc_hb   = st.acc_ctl[3];
   assign idx      = paddr_i[4:2];
   assign is_greg  = (paddr_i[11:5] == 7'(`CMR_GREG_BASE >> 5));
   // pointer update write: bits [2:0] register, bit 3 decrement, bits [7:4] step
   assign ptr_reg  = pwdata_i[2:0];
   assign ptr_dec  = pwdata_i[3];
   assign ptr_step = {28'h0000000, pwdata_i[7:4]};
   assign ptr_full = st.gregs[ptr_reg];

   // ----------------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------------
   always_comb begin
      logic [31:0] sum;
      logic        acc;
      sum     = 32'h00000000;
      next_st = st;
      acc     = psel_i & penable_i & (st.bus == CMR_BUS_RESP);
      // mode pin synchroniser; capture waits until both stages hold the pin
      next_st.mode_sync = {st.mode_sync[0], mode_sel_i};
      next_st.mode_fill = {st.mode_fill[0], 1'b1};
      if (!st.mode_held && st.mode_fill[1]) begin
         next_st.mode      = st.mode_sync[1] ? CMR_MODE_ADVANCED : CMR_MODE_NORMAL;
         next_st.mode_held = 1'b1;
      end
      // apb phase: setup then one access cycle with pready
      next_st.ready  = 1'b0;
      next_st.slverr = 1'b0;
      unique case (st.bus)
         CMR_BUS_IDLE: if (psel_i && !penable_i) begin
            next_st.bus   = CMR_BUS_RESP;
            next_st.ready = 1'b1;
         end
         CMR_BUS_RESP: next_st.bus = CMR_BUS_IDLE;
      endcase
      // read data, prepared alongside pready
      if (psel_i && !penable_i && st.bus == CMR_BUS_IDLE) begin
         next_st.rdata = 32'h00000000;
         if (is_greg) begin
            next_st.rdata = cmr_view(st.gregs[idx], acc_w, acc_up, acc_hb);
         end else begin
            unique case (paddr_i)
               `CMR_PC_OFS:      next_st.rdata = {8'h00, st.pc};
               `CMR_EXTCTL_OFS:  next_st.rdata = {24'h000000, st.extended_control};
               `CMR_MODE_OFS:    next_st.rdata = {30'h00000000, st.mode};
               `CMR_ACCESS_OFS:  next_st.rdata = {24'h000000, st.acc_ctl};
               `CMR_EA_OFS:      next_st.rdata = st.ea_in;
               `CMR_EA_OUT_OFS:  next_st.rdata = st.ea_out;
               `CMR_VEC_OFS:     next_st.rdata = st.vec_raw;
               `CMR_VEC_OUT_OFS: next_st.rdata = st.vec_out;
               `CMR_STACK_OFS:   next_st.rdata = st.gregs[7];
               default:          next_st.slverr = 1'b1;
            endcase
         end
      end
      // writes take effect at the access edge
      if (acc && pwrite_i) begin
         if (is_greg) begin
            next_st.gregs[idx] = cmr_merge(st.gregs[idx], pwdata_i, acc_w,
                                           acc_up, acc_hb);
         end else begin
            unique case (paddr_i)
               `CMR_PC_OFS:     next_st.pc = pwdata_i[23:0];
               `CMR_EXTCTL_OFS: next_st.extended_control =
                                   pwdata_i[7:0] | `CMR_EXT_RSVD_MASK;
               `CMR_ACCESS_OFS: next_st.acc_ctl = pwdata_i[7:0];
               `CMR_EA_OFS: begin
                  next_st.ea_in  = pwdata_i;
                  next_st.ea_out = cmr_ea_mask(pwdata_i, st.mode);
                  // the low byte stands for the 8-bit absolute field of an indirect jump
                  next_st.mi_addr = {24'h000000, pwdata_i[7:0]};
               end
               `CMR_VEC_OFS: begin
                  // vector entry or memory-indirect operand
                  next_st.vec_raw = pwdata_i;
                  if (st.mode == CMR_MODE_NORMAL)
                     next_st.vec_out = {16'h0000, pwdata_i[15:0]};
                  else
                     next_st.vec_out = {8'h00, pwdata_i[23:0]};
               end
               `CMR_PTR_OFS: begin
                  // post-increment / pre-decrement on a pointer register
                  sum = ptr_dec ? ptr_full - ptr_step : ptr_full + ptr_step;
                  if (st.mode == CMR_MODE_NORMAL)
                     next_st.gregs[ptr_reg] = sum;
                  else
                     next_st.gregs[ptr_reg] = sum;
               end
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------------
   // one register stage for the whole state; reset loads constants only
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st                  <= '0;
         st.pc               <= `CMR_PC_RESET;
         st.extended_control <= `CMR_EXT_RESET;
         st.mode             <= CMR_MODE_NORMAL;
         st.bus              <= CMR_BUS_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from flip-flops
   assign prdata_o     = st.rdata;
   assign pready_o     = st.ready;
   assign pslverr_o    = st.slverr;
   assign mode_o       = st.mode;
   assign fetch_addr_o = {st.pc[23:1], 1'b0};
   assign stack_ptr_o  = st.gregs[7];

   // ----------------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------------
   property p_ea_norm;
      @(posedge sys_clk_i) disable iff (rst_i)
      (st.mode == CMR_MODE_NORMAL) |-> (st.ea_out[31:16] == 16'h0000);
   endproperty
   a_ea_norm: assert property (p_ea_norm) else $error("normal ea over 64k");
   property p_ea_adv;
      @(posedge sys_clk_i) disable iff (rst_i)
      (st.mode == CMR_MODE_ADVANCED) |-> (st.ea_out[31:24] == 8'h00);
   endproperty
   a_ea_adv: assert property (p_ea_adv) else $error("advanced ea over 16m");
   property p_mode_hold;
      @(posedge sys_clk_i) disable iff (rst_i)
      st.mode_held |=> $stable(st.mode);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode changed");
   property p_rsvd;
      @(posedge sys_clk_i) disable iff (rst_i)
      st.extended_control[6:3] == 4'hf;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits not one");
   property p_fetch;
      @(posedge sys_clk_i) disable iff (rst_i)
      fetch_addr_o[0] == 1'b0 ##0 fetch_addr_o[23:1] == st.pc[23:1];
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch lsb set");
   property p_vec_adv;
      @(posedge sys_clk_i) disable iff (rst_i)
      (st.mode == CMR_MODE_ADVANCED) |-> st.vec_out[31:24] == 8'h00;
   endproperty
   a_vec_adv: assert property (p_vec_adv) else $error("vector top byte");
   property p_vec_norm;
      @(posedge sys_clk_i) disable iff (rst_i)
      (st.mode == CMR_MODE_NORMAL) |-> st.vec_out[31:16] == 16'h0000;
   endproperty
   a_vec_norm: assert property (p_vec_norm) else $error("normal vector wide");
   property p_ready;
      @(posedge sys_clk_i) disable iff (rst_i)
      (psel_i && !penable_i && st.bus == CMR_BUS_IDLE) |=> pready_o ##1 !pready_o;
   endproperty
   a_ready: assert property (p_ready) else $error("pready timing");
   // an access-phase write as the slave accepts it
   logic wr_acc;
   assign wr_acc = psel_i & penable_i & pwrite_i & (st.bus == CMR_BUS_RESP);
   // an 8-bit absolute field never reaches past the low page
   property p_mi_range;
      @(posedge sys_clk_i) disable iff (rst_i)
      st.mi_addr <= `CMR_MI_LIMIT;
   endproperty
   a_mi_range: assert property (p_mi_range) else $error("operand past 0xff");
   // the trace bit keeps what software wrote
   property p_trace_wr;
      @(posedge sys_clk_i) disable iff (rst_i)
      (wr_acc && paddr_i == `CMR_EXTCTL_OFS) |=>
         st.extended_control[`CMR_EXT_TRACE_BIT] == $past(pwdata_i[7]);
   endproperty
   a_trace_wr: assert property (p_trace_wr) else $error("trace bit lost");
   // the mask bits keep what software wrote
   property p_mask_wr;
      @(posedge sys_clk_i) disable iff (rst_i)
      (wr_acc && paddr_i == `CMR_EXTCTL_OFS) |=>
         st.extended_control[2:0] == $past(pwdata_i[2:0]);
   endproperty
   a_mask_wr: assert property (p_mask_wr) else $error("mask bits lost");
   // a pointer step works on the full register, so carries reach the upper half
   property p_ptr_step;
      @(posedge sys_clk_i) disable iff (rst_i)
      (wr_acc && paddr_i == `CMR_PTR_OFS) |=>
         st.gregs[$past(ptr_reg)] ==
            $past(ptr_dec ? ptr_full - ptr_step : ptr_full + ptr_step);
   endproperty
   a_ptr_step: assert property (p_ptr_step) else $error("pointer step lost carry");
   // a normal-mode vector word passes its low 16 bits unchanged
   property p_vec_norm_val;
      @(posedge sys_clk_i) disable iff (rst_i)
      (wr_acc && paddr_i == `CMR_VEC_OFS && st.mode == CMR_MODE_NORMAL) |=>
         st.vec_out[15:0] == $past(pwdata_i[15:0]);
   endproperty
   a_vec_norm_val: assert property (p_vec_norm_val) else $error("target lost");
   // an advanced-mode entry keeps its low 24 bits as the target
   property p_vec_adv_val;
      @(posedge sys_clk_i) disable iff (rst_i)
      (wr_acc && paddr_i == `CMR_VEC_OFS && st.mode == CMR_MODE_ADVANCED) |=>
         st.vec_out[23:0] == $past(pwdata_i[23:0]);
   endproperty
   a_vec_adv_val: assert property (p_vec_adv_val) else $error("target cut");
   // the mode register only ever holds one of the two legal codes
   property p_mode_legal;
      @(posedge sys_clk_i) disable iff (rst_i)
      (mode_o == CMR_MODE_NORMAL) || (mode_o == CMR_MODE_ADVANCED);
   endproperty
   a_mode_legal: assert property (p_mode_legal) else $error("mode code illegal");
   // a full-width write lands whole in the addressed register
   property p_greg_wr;
      @(posedge sys_clk_i) disable iff (rst_i)
      (wr_acc && is_greg && acc_w == CMR_W_LONG) |=> st.gregs[$past(idx)] == $past(pwdata_i);
   endproperty
   a_greg_wr: assert property (p_greg_wr) else $error("register write lost");
   // a read of extended control always shows the reserved bits as ones
   property p_rsvd_rd;
      @(posedge sys_clk_i) disable iff (rst_i)
      (psel_i && !penable_i && st.bus == CMR_BUS_IDLE && paddr_i == `CMR_EXTCTL_OFS) |=>
         prdata_o[6:3] == 4'hf;
   endproperty
   a_rsvd_rd: assert property (p_rsvd_rd) else $error("reserved bits read low");
   // main scenarios: writes, reads, advanced mode, pointer steps, refused reads
   c_write: cover property (@(posedge sys_clk_i) disable iff (rst_i) pready_o && pwrite_i);
   c_read:  cover property (@(posedge sys_clk_i) disable iff (rst_i) pready_o && !pwrite_i);
   c_adv:   cover property (@(posedge sys_clk_i) disable iff (rst_i)
                            st.mode == CMR_MODE_ADVANCED);
   c_ptr:   cover property (@(posedge sys_clk_i) disable iff (rst_i)
                            wr_acc && paddr_i == `CMR_PTR_OFS);
   c_err:   cover property (@(posedge sys_clk_i) disable iff (rst_i) pslverr_o);
endmodule : cmr_core

// *** test/testbench.sv ***
// Purpose: self-checking bench for the cpu mode and register file block
// Assumes: apb slave answers with pready_o, mode pin settled while reset is held
// Notes:   random data from a fixed seed mixed with hand-picked corner values
`timescale 1ns/100ps
`include "cmr_regs.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; \
   $display("unexpected t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
   import cmr_pkg::*;
   // ------------------------------------------------------------------------
   // signals
   // ------------------------------------------------------------------------
   logic            sys_clk_i;
   logic            rst_i;
   logic            mode_sel_i;
   logic            psel_i;
   logic            penable_i;
   logic            pwrite_i;
   logic [11:0]     paddr_i;
   logic [31:0]     pwdata_i;
   logic [31:0]     prdata_o;
   logic            pready_o;
   logic            pslverr_o;
   cmr_mode_t       mode_o;
   logic [23:0]     fetch_addr_o;
   logic [31:0]     stack_ptr_o;
   int              err_count;
   int              checks;
   int              cyc;
   int              seed;
   logic [31:0]     rd;
   logic [31:0]     d;
   logic [31:0]     old;
   logic [31:0]     regs [8];
   logic            er;
   cmr_core i_cmr_core (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .mode_sel_i(mode_sel_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .mode_o(mode_o), .fetch_addr_o(fetch_addr_o),
      .stack_ptr_o(stack_ptr_o));
   // ------------------------------------------------------------------------
   // clock, timeout and helpers
   // ------------------------------------------------------------------------
   // 50 MHz clock
   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   // cut a hang short
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up
   // one apb transfer: setup, access until pready, then release
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= wd;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge sys_clk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      er = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask : apb
   // reset with the mode pin held at m
   task automatic do_reset(input logic m);
      rst_i      <= 1'b1;
      mode_sel_i <= m;
      repeat (10) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      // mode is caught at the third edge; look one edge later
      repeat (4) @(posedge sys_clk_i);
   endtask : do_reset
   function automatic logic [31:0] ext_exp(input logic [31:0] v);
      return {24'h0, v[7], 4'hf, v[2:0]};
   endfunction : ext_exp
   function automatic logic [31:0] mask_exp(input logic adv, input logic [31:0] v);
      return adv ? {8'h0, v[23:0]} : {16'h0, v[15:0]};
   endfunction : mask_exp
   // merge of a narrow view write into the full register
   function automatic logic [31:0] view_exp(input logic [3:0] acc, input logic [31:0] o,
                                            input logic [31:0] v);
      case (acc)
         4'h1:    return {o[31:16], v[15:0]};
         4'h5:    return {v[15:0], o[15:0]};
         4'h2:    return {o[31:8], v[7:0]};
         4'ha:    return {o[31:16], v[7:0], o[7:0]};
         default: return v;
      endcase
   endfunction : view_exp
   // ------------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------------
   initial begin
      logic [3:0] views [4];
      views = '{4'h1, 4'h5, 4'h2, 4'ha};
      seed = 32'h03fd; err_count = 0; checks = 0; cyc = 0;
      rst_i = 1'b1; mode_sel_i = 1'b0; psel_i = 1'b0; penable_i = 1'b0;
      pwrite_i = 1'b0; paddr_i = 12'h000; pwdata_i = 32'h0;
      do_reset(1'b0);
      `CHK(mode_o, CMR_MODE_NORMAL)
      `CHK(fetch_addr_o, 24'h000000)
      apb(1'b0, `CMR_EXTCTL_OFS, 32'h0);
      `CHK(rd, 32'h0000007f)
      // mode pin moves after reset: mode must hold
      mode_sel_i <= 1'b1;
      repeat (6) @(posedge sys_clk_i);
      `CHK(mode_o, CMR_MODE_NORMAL)
      apb(1'b0, `CMR_MODE_OFS, 32'h0);
      `CHK(rd[1:0], 2'h1)
      // extended control: corners then random
      for (int i = 0; i < 6; i++) begin
         d = (i == 0) ? 32'h0 : (i == 1) ? 32'hff : $random(seed);
         apb(1'b1, `CMR_EXTCTL_OFS, d);
         apb(1'b0, `CMR_EXTCTL_OFS, 32'h0);
         `CHK(rd, ext_exp(d))
         `CHK(rd[2:0], d[2:0])
      end
      // program counter: lsb forced low on fetch
      for (int i = 0; i < 4; i++) begin
         d = $random(seed) | 32'h1;
         apb(1'b1, `CMR_PC_OFS, d);
         `CHK(fetch_addr_o, {d[23:1], 1'b0})
      end
      // general registers at full width
      apb(1'b1, `CMR_ACCESS_OFS, 32'h0);
      for (int i = 0; i < 8; i++) begin
         regs[i] = $random(seed);
         apb(1'b1, `CMR_GREG_BASE + 12'(4 * i), regs[i]);
      end
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, `CMR_GREG_BASE + 12'(4 * i), 32'h0);
         `CHK(rd, regs[i])
      end
      `CHK(stack_ptr_o, regs[7])
      apb(1'b0, `CMR_STACK_OFS, 32'h0);
      `CHK(rd, regs[7])
      // narrow views only touch their own part
      for (int v = 0; v < 4; v++) begin
         old = regs[v + 1];
         d = $random(seed);
         apb(1'b1, `CMR_ACCESS_OFS, {28'h0, views[v]});
         apb(1'b1, `CMR_GREG_BASE + 12'(4 * (v + 1)), d);
         apb(1'b1, `CMR_ACCESS_OFS, 32'h0);
         apb(1'b0, `CMR_GREG_BASE + 12'(4 * (v + 1)), 32'h0);
         `CHK(rd, view_exp(views[v], old, d))
         apb(1'b0, `CMR_GREG_BASE, 32'h0);
         `CHK(rd, regs[0])
      end
      // pointer step carry and borrow cross into the upper half
      apb(1'b1, `CMR_GREG_BASE + 12'h8, 32'h0000ffff);
      apb(1'b1, `CMR_PTR_OFS, 32'h12);
      apb(1'b0, `CMR_GREG_BASE + 12'h8, 32'h0);
      `CHK(rd, 32'h00010000)
      apb(1'b1, `CMR_GREG_BASE + 12'hc, 32'h00010000);
      apb(1'b1, `CMR_PTR_OFS, 32'h2b);
      apb(1'b0, `CMR_GREG_BASE + 12'hc, 32'h0);
      `CHK(rd, 32'h0000fffe)
      // unmapped read is refused
      apb(1'b0, 12'h080, 32'h0);
      `CHK(er, 1'b1)
      `CHK(rd, 32'h0)
      // address and vector forms in both modes
      for (int m = 0; m < 2; m++) begin
         if (m == 1) begin
            do_reset(1'b1);
            `CHK(mode_o, CMR_MODE_ADVANCED)
            apb(1'b0, `CMR_EXTCTL_OFS, 32'h0);
            `CHK(rd, 32'h0000007f)
         end
         for (int i = 0; i < 5; i++) begin
            d = (i == 0) ? 32'hffffffff : $random(seed);
            apb(1'b1, `CMR_EA_OFS, d);
            apb(1'b0, `CMR_EA_OUT_OFS, 32'h0);
            `CHK(rd, mask_exp(m[0], d))
            apb(1'b1, `CMR_VEC_OFS, d);
            apb(1'b0, `CMR_VEC_OUT_OFS, 32'h0);
            `CHK(rd, mask_exp(m[0], d))
         end
      end
      wrap_up();
   end
endmodule : testbench
